/* File: verilog/prec_top.sv */
// Parity, device reset, rate select, framer and elasticity control.
`timescale 1ns/1ps
// How it works
// - High reframe mode needs four adjacent matches.
// - Realignment never stalls the character stream.
// - Parity off disables check and parity output.
// - Mid with codec on covers data only.
// - Mid with codec off adds two control bits.
// - High covers data, control and three status.
// - Rate select sets the PLL range code.
// - Device reset clears state and empties the buffer.
// - Outputs settle within sixteen cycles after reset.
// - Device reset clears the three control latches.
// - Transmit select low captures data on reference.
// - Receive select low enables the elasticity buffer.
// - Rate mismatch fixed only by framing characters.
// - Insert one framing character after one seen.
// - Delete a framing character where one seen.
// - Decoder low passes raw characters, needs mid.
module prec_top #(
  parameter int CHAR_W = 10,
  parameter int EB_DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic device_reset_n,
  input wire logic [1:0] parity_control,
  input wire logic [1:0] serial_rate_select,
  input wire logic [1:0] tx_ref_rate_select,
  input wire logic [1:0] reframe_mode_select,
  input wire logic [1:0] decoder_mode_select,
  input wire logic [1:0] tx_encoder_mode,
  input wire logic [1:0] tx_clock_select,
  input wire logic [1:0] rx_clock_select,
  input wire logic selftest_latch_enable,
  input wire logic output_enable_latch_enable,
  input wire logic rx_latch_enable,
  input wire logic [7:0] tx_parallel_data,
  input wire logic [1:0] tx_char_control,
  input wire logic tx_parity_in,
  input wire logic tx_valid,
  input wire logic [CHAR_W-1:0] rx_raw_char,
  input wire logic rx_raw_valid,
  output logic rx_raw_ready_r,
  input wire logic rx_out_ready,
  output logic [9:0] tx_capture_r,
  output logic tx_capture_valid_r,
  output logic tx_parity_error_r,
  output logic [7:0] rx_parallel_data_r,
  output logic [2:0] rx_char_status_r,
  output logic rx_valid_r,
  output logic rx_parity_out_r,
  output logic rx_parity_oe_r,
  output logic [1:0] pll_range_r,
  output logic cfg_invalid_r,
  output logic selftest_le_r,
  output logic oe_le_r,
  output logic rx_le_r,
  output logic framer_locked_r,
  output logic eb_insert_r,
  output logic eb_delete_r
);
  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic is_frame(input logic [9:0] c);
    return (c == prec_pkg::K285_NEG) || (c == prec_pkg::K285_POS);
  endfunction

  // Bit that makes the total count of ones odd.
  function automatic logic odd_bit(input logic [12:0] v);
    return ~(^v);
  endfunction

  // ****************************************************************
  // Pin synchronisers and configuration hold
  // ****************************************************************
  logic [19:0] pins, s1_r, s2_r;
  logic [15:0] cfg_r, cfg_nxt;
  logic dev_rst;
  logic [1:0] c_par, c_rate, c_txr, c_rfm, c_dec, c_enc, c_txck, c_rxck;

  assign pins = {device_reset_n, selftest_latch_enable,
    output_enable_latch_enable, rx_latch_enable, parity_control,
    serial_rate_select, tx_ref_rate_select, reframe_mode_select,
    decoder_mode_select, tx_encoder_mode, tx_clock_select,
    rx_clock_select};
  assign dev_rst = !s2_r[19];
  assign {c_par, c_rate, c_txr, c_rfm, c_dec, c_enc, c_txck, c_rxck} =
    cfg_r;

  // Selects are only followed while the device is held in reset.
  always_comb begin
    cfg_nxt = cfg_r;
    if (dev_rst) cfg_nxt = s2_r[15:0];
  end

  // ****************************************************************
  // Framer
  // ****************************************************************
  logic [9:0] prev_r, prev_nxt;
  logic [19:0] window;
  logic [9:0] hits, aligned;
  logic [3:0] off_r, off_nxt, cand_off_r, cand_off_nxt, hit_off;
  logic [2:0] cand_cnt_r, cand_cnt_nxt, need;
  logic any_hit, raw_fire;
  prec_pkg::prec_frm_t fst_r, fst_nxt;

  assign window = {rx_raw_char, prev_r};
  assign aligned = window[off_r +: 10];

  genvar g;
  generate
    for (g = 0; g < 10; g++) begin : g_hit
      assign hits[g] = is_frame(window[g +: 10]);
    end
  endgenerate

  always_comb begin
    hit_off = prec_pkg::OFFSET_RESET;
    for (int i = 9; i >= 0; i--) begin
      if (hits[i]) hit_off = 4'(i);
    end
  end
  assign any_hit = |hits;

  always_comb begin
    case (c_rfm)
      prec_pkg::LVL_LOW: need = prec_pkg::FRM_NEED_LOW;
      prec_pkg::LVL_MID: need = prec_pkg::FRM_NEED_MID;
      default: need = prec_pkg::FRM_NEED_HIGH;
    endcase
  end

  // ****************************************************************
  // Elasticity buffer and receive output
  // ****************************************************************
  logic [3:0] eb_count;
  logic [9:0] eb_out;
  logic eb_in_valid, eb_in_ready, eb_out_valid, eb_pop;
  logic eb_en, drop, primed_r, primed_nxt, ins_r, ins_nxt;
  logic [9:0] out_char;
  logic out_fire;

  assign eb_en = (c_rxck == prec_pkg::LVL_LOW);
  assign raw_fire = rx_raw_valid && eb_in_ready && !dev_rst;
  // Dropping happens on the way in, from a fill of six, so the deleted character never enters the buffer.
  assign drop = eb_en && (eb_count >= prec_pkg::EB_HIGH_MARK) &&
    is_frame(aligned);
  assign eb_in_valid = raw_fire && !drop;
  assign eb_pop = primed_r && eb_out_valid && rx_out_ready && !ins_r;
  assign out_fire = rx_out_ready && primed_r && (ins_r || eb_out_valid);
  assign out_char = ins_r ? prec_pkg::K285_NEG : eb_out;

  prec_fifo #(.WIDTH(10), .DEPTH(EB_DEPTH)) u_eb (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clr(dev_rst),
    .in_data(aligned),
    .in_valid(eb_in_valid),
    .in_ready(eb_in_ready),
    .out_data(eb_out),
    .out_valid(eb_out_valid),
    .out_ready(eb_pop),
    .count(eb_count)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic [7:0] rxd_nxt;
  logic [2:0] rxs_nxt;
  logic [12:0] tx_cov, rx_cov;
  logic codec_on;

  assign codec_on = (c_enc != prec_pkg::LVL_LOW) &&
    (c_dec != prec_pkg::LVL_LOW);

  always_comb begin
    prev_nxt = prev_r;
    off_nxt = off_r;
    cand_off_nxt = cand_off_r;
    cand_cnt_nxt = cand_cnt_r;
    fst_nxt = fst_r;
    primed_nxt = primed_r;
    ins_nxt = ins_r;
    // Raw mode passes the two high bits out as status.
    rxd_nxt = out_char[7:0];
    rxs_nxt = (c_dec == prec_pkg::LVL_LOW) ? {1'b0, out_char[9:8]} :
      {2'b00, is_frame(out_char)};
    case (c_par)
      prec_pkg::LVL_HIGH: tx_cov = {2'h0, tx_char_control,
        tx_parallel_data, tx_parity_in};
      default: tx_cov = codec_on ? {4'h0, tx_parallel_data,
        tx_parity_in} : {2'h0, tx_char_control, tx_parallel_data,
        tx_parity_in};
    endcase
    case (c_par)
      prec_pkg::LVL_HIGH: rx_cov = {2'b00, rxs_nxt, rxd_nxt};
      default: rx_cov = codec_on ? {5'b00000, rxd_nxt} :
        {3'b000, rxs_nxt[1:0], rxd_nxt};
    endcase
    if (raw_fire) begin
      prev_nxt = rx_raw_char;
      // The output stream keeps its cadence; only the offset moves.
      if (any_hit && hit_off != off_r) begin
        if (fst_r != prec_pkg::FR_HUNT && hit_off == cand_off_r)
          cand_cnt_nxt = cand_cnt_r + 3'h1;
        else
          cand_cnt_nxt = 3'h1;
        cand_off_nxt = hit_off;
        fst_nxt = prec_pkg::FR_CONFIRM;
        if (cand_cnt_nxt >= need) begin
          off_nxt = hit_off;
          cand_cnt_nxt = 3'h0;
          fst_nxt = prec_pkg::FR_LOCKED;
        end
      end else if (any_hit) begin
        cand_cnt_nxt = 3'h0;
        fst_nxt = prec_pkg::FR_LOCKED;
      end else if (fst_r == prec_pkg::FR_CONFIRM && c_rfm ==
          prec_pkg::LVL_HIGH) begin
        // Adjacent matches must not be broken by a plain character.
        cand_cnt_nxt = 3'h0;
        fst_nxt = prec_pkg::FR_HUNT;
      end
    end
    // With the buffer enabled, output waits until it holds its nominal fill.
    if (eb_count >= prec_pkg::EB_NOMINAL || !eb_en) primed_nxt = 1'b1;
    if (out_fire) ins_nxt = 1'b0;
    if (eb_pop && eb_en && eb_count <= prec_pkg::EB_LOW_MARK &&
        is_frame(eb_out)) ins_nxt = 1'b1;
    if (dev_rst) begin
      prev_nxt = 10'h000;
      off_nxt = prec_pkg::OFFSET_RESET;
      cand_off_nxt = prec_pkg::OFFSET_RESET;
      cand_cnt_nxt = 3'h0;
      fst_nxt = prec_pkg::FR_HUNT;
      primed_nxt = 1'b0;
      ins_nxt = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= 20'h0_0000;
      s2_r <= 20'h0_0000;
      cfg_r <= prec_pkg::CFG_RESET;
      prev_r <= 10'h000;
      off_r <= prec_pkg::OFFSET_RESET;
      cand_off_r <= prec_pkg::OFFSET_RESET;
      cand_cnt_r <= 3'h0;
      fst_r <= prec_pkg::FR_HUNT;
      primed_r <= 1'b0;
      ins_r <= 1'b0;
      rx_raw_ready_r <= 1'b0;
      tx_capture_r <= 10'h000;
      tx_capture_valid_r <= 1'b0;
      tx_parity_error_r <= 1'b0;
      rx_parallel_data_r <= 8'h00;
      rx_char_status_r <= 3'h0;
      rx_valid_r <= 1'b0;
      rx_parity_out_r <= 1'b0;
      rx_parity_oe_r <= 1'b0;
      pll_range_r <= 2'h0;
      cfg_invalid_r <= 1'b0;
      selftest_le_r <= 1'b0;
      oe_le_r <= 1'b0;
      rx_le_r <= 1'b0;
      framer_locked_r <= 1'b0;
      eb_insert_r <= 1'b0;
      eb_delete_r <= 1'b0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      cfg_r <= cfg_nxt;
      prev_r <= prev_nxt;
      off_r <= off_nxt;
      cand_off_r <= cand_off_nxt;
      cand_cnt_r <= cand_cnt_nxt;
      fst_r <= fst_nxt;
      primed_r <= primed_nxt;
      ins_r <= ins_nxt;
      rx_raw_ready_r <= eb_in_ready && !dev_rst;
      pll_range_r <= c_rate;
      cfg_invalid_r <= (c_rate == prec_pkg::LVL_LOW &&
        c_txr == prec_pkg::LVL_HIGH) || (c_dec == prec_pkg::LVL_LOW &&
        c_rxck != prec_pkg::LVL_MID);
      selftest_le_r <= !dev_rst && s2_r[18];
      oe_le_r <= !dev_rst && s2_r[17];
      rx_le_r <= !dev_rst && s2_r[16];
      framer_locked_r <= !dev_rst && fst_nxt == prec_pkg::FR_LOCKED;
      eb_insert_r <= !dev_rst && out_fire && ins_r;
      eb_delete_r <= raw_fire && drop;
      tx_capture_valid_r <= !dev_rst && tx_valid &&
        c_txck == prec_pkg::LVL_LOW;
      if (tx_valid && c_txck == prec_pkg::LVL_LOW)
        tx_capture_r <= {tx_char_control, tx_parallel_data};
      tx_parity_error_r <= !dev_rst && tx_valid &&
        c_par != prec_pkg::LVL_LOW && !(^tx_cov);
      rx_valid_r <= !dev_rst && out_fire;
      rx_parity_oe_r <= !dev_rst && c_par != prec_pkg::LVL_LOW;
      if (out_fire) begin
        rx_parallel_data_r <= rxd_nxt;
        rx_char_status_r <= rxs_nxt;
        rx_parity_out_r <= odd_bit(rx_cov);
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_full_frame;
    raw_fire && eb_en && is_frame(aligned) &&
      eb_count >= prec_pkg::EB_HIGH_MARK;
  endsequence

  par_off_a: assert property (c_par == prec_pkg::LVL_LOW |=>
    !rx_parity_oe_r && !tx_parity_error_r)
    else $error("parity active while parity control is low");
  tx_check_a: assert property (tx_valid && !dev_rst &&
    c_par == prec_pkg::LVL_MID && codec_on |=> tx_parity_error_r ==
    !(^$past({tx_parallel_data, tx_parity_in})))
    else $error("transmit parity check wrong in mid mode");
  rx_gen_a: assert property (rx_valid_r &&
    $past(c_par) == prec_pkg::LVL_HIGH |-> ^{rx_char_status_r,
    rx_parallel_data_r, rx_parity_out_r})
    else $error("receive parity not odd in high mode");
  rate_map_a: assert property (!dev_rst ##1 !dev_rst |->
    pll_range_r == $past(c_rate))
    else $error("rate range does not follow select");
  reset_clear_a: assert property (dev_rst |=>
    !selftest_le_r && !oe_le_r && !rx_le_r && !rx_valid_r)
    else $error("latch or output not cleared by device reset");
  reset_state_a: assert property (dev_rst |=>
    eb_count == 4'h0 && fst_r == prec_pkg::FR_HUNT && !primed_r)
    else $error("state not reset by device reset");
  frame_four_a: assert property ($changed(off_r) &&
    c_rfm == prec_pkg::LVL_HIGH && !dev_rst |-> $past(cand_cnt_r) == 3)
    else $error("boundary moved before four adjacent matches");
  // With the decoder on, status bit 0 flags the framing character.
  insert_a: assert property (eb_insert_r |->
    rx_valid_r && rx_parallel_data_r == 8'hfa &&
    (c_dec == prec_pkg::LVL_LOW || rx_char_status_r == 3'h1))
    else $error("inserted character is not a framing character");
  delete_a: assert property (s_full_frame |=> eb_delete_r)
    else $error("framing character not deleted at high fill");
endmodule

/* File: verilog/prec_pkg.sv */
// Constants shared by the parity, reset and elasticity control block.
package prec_pkg;
  // Three-level select codes as they arrive on the 2-bit select ports.
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  // Framing character in both running disparities.
  localparam logic [9:0] K285_NEG = 10'h0fa;
  localparam logic [9:0] K285_POS = 10'h305;
  // Matches needed before the framer moves its boundary, per mode.
  localparam logic [2:0] FRM_NEED_LOW = 3'h1;
  localparam logic [2:0] FRM_NEED_MID = 3'h2;
  localparam logic [2:0] FRM_NEED_HIGH = 3'h4;
  // Elasticity buffer fill levels.
  localparam logic [3:0] EB_NOMINAL = 4'h4;
  localparam logic [3:0] EB_HIGH_MARK = 4'h6;
  localparam logic [3:0] EB_LOW_MARK = 4'h2;
  // Reset values.
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [3:0] OFFSET_RESET = 4'h0;
  // Upper bound on cycles from reset release to settled outputs.
  localparam int SETTLE_CYCLES = 16;
  // Framer states.
  typedef enum logic [2:0] {
    FR_HUNT = 3'b001,
    FR_CONFIRM = 3'b010,
    FR_LOCKED = 3'b100
  } prec_frm_t;
endpackage

/* File: verilog/prec_fifo.sv */
// Elasticity FIFO with valid/ready on both sides and a fill count.
`timescale 1ns/1ps
module prec_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic push, pop;

  assign count = wr_r - rd_r;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    if (clr) begin
      wr_nxt = '0;
      rd_nxt = '0;
    end else begin
      if (push) wr_nxt = wr_r + 1'b1;
      if (pop) rd_nxt = rd_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Storage has no reset; only words below the write pointer are read.
  always_ff @(posedge ref_clk) begin
    if (push && !clr) mem[wr_r[AW-1:0]] <= in_data;
  end
endmodule

/* File: verification/prec_host.sv */
// Host-side model that feeds recovered characters and drains the output.
`timescale 1ns/1ps
module prec_host (
  input wire logic ref_clk,
  input wire logic rx_raw_ready_r,
  output logic [9:0] rx_raw_char,
  output logic rx_raw_valid,
  output logic rx_out_ready
);
  initial begin
    rx_raw_char = 10'h000;
    rx_raw_valid = 1'b0;
    rx_out_ready = 1'b0;
  end
  // A refused character is dropped after a long wait, so a full buffer
  // cannot hang the run; the data lines keep toggling meanwhile.
  task automatic send(input logic [9:0] c);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (rx_raw_ready_r !== 1'b1 && n < 64) begin
      rx_raw_valid = 1'b0;
      rx_raw_char = ~rx_raw_char;
      n++;
      @(negedge ref_clk);
    end
    if (n < 64) begin
      rx_raw_char = c;
      rx_raw_valid = 1'b1;
      @(posedge ref_clk);
    end
  endtask
  task automatic idle();
    @(negedge ref_clk);
    rx_raw_valid = 1'b0;
    rx_raw_char = ~rx_raw_char;
  endtask
  task automatic drain(input logic on);
    @(negedge ref_clk);
    rx_out_ready = on;
  endtask
endmodule

/* File: verification/prec_top_tb_top.sv */
// Self-checking testbench for the parity, reset and elasticity block.
`timescale 1ns/1ps
module prec_top_tb_top;
  localparam logic [1:0] LO = prec_pkg::LVL_LOW;
  localparam logic [1:0] MI = prec_pkg::LVL_MID;
  localparam logic [1:0] HI = prec_pkg::LVL_HIGH;
  localparam logic [9:0] FIL = 10'h2a5;
  localparam logic [9:0] KN = prec_pkg::K285_NEG;
  // Framing character rotated so it frames three bits off the boundary.
  localparam logic [9:0] KR = 10'h3d1;
  logic ref_clk = 1'b0;
  logic rstn;
  logic device_reset_n;
  logic [1:0] parity_control, serial_rate_select, tx_ref_rate_select;
  logic [1:0] reframe_mode_select, decoder_mode_select, tx_encoder_mode;
  logic [1:0] tx_clock_select, rx_clock_select;
  logic selftest_latch_enable, output_enable_latch_enable, rx_latch_enable;
  logic [7:0] tx_parallel_data;
  logic [1:0] tx_char_control;
  logic tx_parity_in, tx_valid, rx_raw_valid, rx_raw_ready_r, rx_out_ready;
  logic [9:0] rx_raw_char, tx_capture_r;
  logic tx_capture_valid_r, tx_parity_error_r, rx_valid_r;
  logic [7:0] rx_parallel_data_r, last_d;
  logic [2:0] rx_char_status_r, last_s, es;
  logic rx_parity_out_r, rx_parity_oe_r, cfg_invalid_r, last_p;
  logic [1:0] pll_range_r;
  logic selftest_le_r, oe_le_r, rx_le_r, framer_locked_r;
  logic eb_insert_r, eb_delete_r;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int out_cnt = 0;
  int fa_cnt = 0;
  int ins_cnt = 0;
  int del_cnt = 0;

  prec_top uut (.ref_clk, .rstn, .device_reset_n, .parity_control,
    .serial_rate_select, .tx_ref_rate_select, .reframe_mode_select,
    .decoder_mode_select, .tx_encoder_mode, .tx_clock_select,
    .rx_clock_select, .selftest_latch_enable, .output_enable_latch_enable,
    .rx_latch_enable, .tx_parallel_data, .tx_char_control, .tx_parity_in,
    .tx_valid, .rx_raw_char, .rx_raw_valid, .rx_raw_ready_r, .rx_out_ready,
    .tx_capture_r, .tx_capture_valid_r, .tx_parity_error_r,
    .rx_parallel_data_r, .rx_char_status_r, .rx_valid_r, .rx_parity_out_r,
    .rx_parity_oe_r, .pll_range_r, .cfg_invalid_r, .selftest_le_r, .oe_le_r,
    .rx_le_r, .framer_locked_r, .eb_insert_r, .eb_delete_r);
  prec_host host (.ref_clk, .rx_raw_ready_r, .rx_raw_char, .rx_raw_valid,
    .rx_out_ready);

  always #2.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (rx_valid_r === 1'b1) begin
      out_cnt <= out_cnt + 1;
      last_d <= rx_parallel_data_r;
      last_s <= rx_char_status_r;
      last_p <= rx_parity_out_r;
      if (rx_parallel_data_r === 8'hfa) fa_cnt <= fa_cnt + 1;
    end
    if (eb_insert_r === 1'b1) ins_cnt <= ins_cnt + 1;
    if (eb_delete_r === 1'b1) del_cnt <= del_cnt + 1;
  end

  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      end_sim();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic txerr(input logic [1:0] p, enc, dec,
    input logic [7:0] d, input logic [1:0] c, input logic par);
    if (p == LO) return 1'b0;
    if (p == MI && enc != LO && dec != LO) return ~^{d, par};
    return ~^{d, c, par};
  endfunction

  function automatic logic rxpar(input logic [1:0] p, enc, dec,
    input logic [7:0] d, input logic [2:0] s);
    if (p == HI) return ~^{d, s};
    if (enc != LO && dec != LO) return ~^d;
    return ~^{d, s[1:0]};
  endfunction

  task automatic dev_reset(input logic [1:0] p, rate, txr, rf, dec, enc,
    txck, rxck);
    logic inv;
    inv = (rate == LO && txr == HI) || (dec == LO && rxck != MI);
    @(negedge ref_clk);
    parity_control = p;
    serial_rate_select = rate;
    tx_ref_rate_select = txr;
    reframe_mode_select = rf;
    decoder_mode_select = dec;
    tx_encoder_mode = enc;
    tx_clock_select = txck;
    rx_clock_select = rxck;
    device_reset_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({selftest_le_r, oe_le_r, rx_le_r}, 3'h0);
    chk({framer_locked_r, rx_valid_r, eb_insert_r, eb_delete_r}, 4'h0);
    device_reset_n = 1'b1;
    repeat (15) @(negedge ref_clk);
    chk({selftest_le_r, oe_le_r, rx_le_r}, 3'h7);
    chk(pll_range_r, rate);
    chk(cfg_invalid_r, inv);
    chk(rx_parity_oe_r, p != LO);
  endtask

  // Two back-to-back words: the first has odd parity over data alone,
  // the second has odd parity only once the control bits are counted.
  task automatic tx_pair(input logic [1:0] p, enc, dec, input logic cap);
    @(negedge ref_clk);
    tx_parallel_data = 8'h5b;
    tx_char_control = 2'h1;
    tx_parity_in = ~^8'h5b;
    tx_valid = 1'b1;
    @(negedge ref_clk);
    tx_parallel_data = 8'hc3;
    tx_char_control = 2'h2;
    tx_parity_in = ^8'hc3;
    chk(tx_capture_valid_r, cap);
    if (cap) chk(tx_parity_error_r, txerr(p, enc, dec, 8'h5b, 2'h1, 1'b0));
    if (cap) chk(tx_capture_r, {2'h1, 8'h5b});
    @(negedge ref_clk);
    tx_valid = 1'b0;
    chk(tx_capture_valid_r, cap);
    if (cap) chk(tx_parity_error_r, txerr(p, enc, dec, 8'hc3, 2'h2, 1'b0));
    if (cap) chk(tx_capture_r, {2'h2, 8'hc3});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic parity_mode(input logic [1:0] p, enc, dec, rate, txr);
    int b;
    dev_reset(p, rate, txr, LO, dec, enc, LO, MI);
    @(negedge ref_clk);
    parity_control = (p == LO) ? HI : LO;
    tx_pair(p, enc, dec, 1'b1);
    host.drain(1'b1);
    b = out_cnt;
    repeat (8) host.send(FIL);
    host.idle();
    repeat (12) @(negedge ref_clk);
    es = (dec == LO) ? 3'h2 : 3'h0;
    chk(out_cnt - b, 8);
    chk(last_d, 8'ha5);
    chk(last_s, es);
    if (p != LO) chk(last_p, rxpar(p, enc, dec, 8'ha5, es));
    chk(rx_parity_oe_r, p != LO);
  endtask

  task automatic framer_high();
    int b;
    dev_reset(MI, HI, LO, HI, MI, MI, LO, MI);
    host.drain(1'b1);
    b = out_cnt;
    // Three adjacent matches at the new boundary must not move it.
    repeat (2) host.send(10'h000);
    repeat (4) host.send(KR);
    repeat (2) host.send(10'h000);
    host.idle();
    repeat (10) @(negedge ref_clk);
    chk(framer_locked_r, 1'b0);
    repeat (5) host.send(KR);
    repeat (2) host.send(10'h000);
    host.idle();
    repeat (10) @(negedge ref_clk);
    chk(framer_locked_r, 1'b1);
    chk(out_cnt - b, 15);
  endtask

  task automatic eb_delete();
    int d0, i0, f0;
    dev_reset(MI, MI, LO, LO, MI, MI, MI, LO);
    tx_pair(MI, MI, MI, 1'b0);
    host.drain(1'b0);
    d0 = del_cnt;
    i0 = ins_cnt;
    f0 = fa_cnt;
    // The framing character reaches the buffer input at a fill of six.
    repeat (5) host.send(FIL);
    host.send(KN);
    repeat (3) host.send(FIL);
    host.idle();
    @(negedge ref_clk);
    chk(rx_raw_ready_r, 1'b0);
    chk(del_cnt - d0, 1);
    host.drain(1'b1);
    repeat (30) @(negedge ref_clk);
    chk(fa_cnt - f0, 0);
    chk(ins_cnt - i0, 0);
    chk(rx_raw_ready_r, 1'b1);
  endtask

  task automatic eb_insert();
    int i0, f0;
    dev_reset(MI, MI, LO, LO, MI, MI, LO, LO);
    host.drain(1'b1);
    i0 = ins_cnt;
    f0 = fa_cnt;
    repeat (3) host.send(FIL);
    host.send(KN);
    repeat (2) host.send(FIL);
    host.idle();
    repeat (30) @(negedge ref_clk);
    chk(ins_cnt - i0, 1);
    chk(fa_cnt - f0, 2);
  endtask

  initial begin
    rstn = 1'b0;
    device_reset_n = 1'b0;
    {parity_control, serial_rate_select, tx_ref_rate_select} = 6'h15;
    {reframe_mode_select, decoder_mode_select, tx_encoder_mode} = 6'h15;
    {tx_clock_select, rx_clock_select} = 4'h5;
    {selftest_latch_enable, output_enable_latch_enable} = 2'h3;
    rx_latch_enable = 1'b1;
    tx_parallel_data = 8'h00;
    tx_char_control = 2'h0;
    tx_parity_in = 1'b0;
    tx_valid = 1'b0;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    parity_mode(HI, MI, LO, HI, MI);
    parity_mode(MI, MI, MI, MI, HI);
    parity_mode(MI, LO, LO, LO, HI);
    parity_mode(LO, MI, MI, MI, LO);
    framer_high();
    eb_delete();
    eb_insert();
    end_sim();
  end
endmodule
